// ==== dv/bfp_lamp_model.sv ====
// Half-bridge and lamp stand-in that produces the current sense flags
`timescale 1ns/1ps
module bfp_lamp_model (
	// Gate drive from the block
	input wire logic high_side_gate_out,
	input wire logic low_side_gate_out,
	// Fault commands from the bench
	input wire logic over_cmd,
	input wire logic under_cmd,
	// Current sense flags
	output logic cs_above_over,
	output logic cs_below_under
);
	// ------------------------------------------------------------
	// Sense resistor under the low switch
	// ------------------------------------------------------------
	// Current only flows while the low switch conducts; shoot-through reads as over-current
	assign cs_above_over = low_side_gate_out & (over_cmd | high_side_gate_out);
	// No conduction reads as under-current; a weak lamp reads low while on
	assign cs_below_under = ~low_side_gate_out | under_cmd;
endmodule : bfp_lamp_model

// ==== dv/bfp_top_tb_top.sv ====
// Self-checking bench for the ballast protection and restart supervisor
`timescale 1ns/1ps
module bfp_top_tb_top;
	import bfp_pkg::*;
	localparam int HC = 20;
	localparam int DT = 3;
	localparam int LIMIT = 5000;
	// Rows: uv lock, bus start, bus stop, shutdown high, shutdown low -> osc_enable, micropower
	localparam logic [6:0] ROWS [5] = '{7'h70, 7'h00, 7'h10, 7'h3D, 7'h32};
	logic clk_sys, nrst, ce, uv_lock, bs, bst, sdh, sdl, phe, phi, ovr, und;
	logic cs_over, cs_under, osc_enable, hs, ls, preheat_release, run_select;
	logic micropower, fault_latched;
	int miscompares = 0;
	int checks = 0;
	int cycles = 0;

	bfp_top #(.HALF_CYC(HC), .DEAD(DT)) dut (.clk_sys(clk_sys), .nrst(nrst), .ce(ce),
		.supply_undervoltage_lock(uv_lock), .bus_above_start(bs), .bus_above_stop(bst),
		.shutdown_above_high(sdh), .shutdown_above_low(sdl), .cs_above_over(cs_over),
		.cs_below_under(cs_under), .preheat_node_above_end(phe),
		.preheat_node_above_ignite(phi), .osc_enable(osc_enable),
		.high_side_gate_out(hs), .low_side_gate_out(ls),
		.preheat_release(preheat_release), .run_select(run_select),
		.micropower(micropower), .fault_latched(fault_latched));

	bfp_lamp_model lamp (.high_side_gate_out(hs), .low_side_gate_out(ls),
		.over_cmd(ovr), .under_cmd(und), .cs_above_over(cs_over),
		.cs_below_under(cs_under));

	// ------------------------------------------------------------
	// Clock, timeout and helpers
	// ------------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	task automatic test_done();
		if (miscompares == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : test_done

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == LIMIT) begin
			miscompares++;
			test_done();
		end
	end

	task automatic chk(input logic [1:0] got, input logic [1:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	function automatic logic pick(input int s);
		case (s)
			0: return osc_enable;
			1: return preheat_release;
			2: return run_select;
			default: return fault_latched;
		endcase
	endfunction : pick

	// Wait up to n cycles for an output to reach v, then compare it
	task automatic wait_for(input int s, input logic v, input int n);
		for (int i = 0; i < n && pick(s) !== v; i++) @(negedge clk_sys);
		chk({1'b0, pick(s)}, {1'b0, v});
	endtask : wait_for

	task automatic idle(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : idle

	task automatic off_chk(input logic mp);
		chk({osc_enable, micropower}, {1'b0, mp});
		chk({hs, ls}, 2'h0);
	endtask : off_chk

	// Both gates must each switch on and never overlap
	task automatic gates(input int n);
		logic [1:0] seen;
		logic both;
		seen = 2'h0;
		both = 1'b0;
		repeat (n) begin
			@(negedge clk_sys);
			seen = seen | {hs, ls};
			both = both | (hs & ls);
		end
		chk(seen, 2'h3);
		chk({1'b0, both}, 2'h0);
	endtask : gates

	// ------------------------------------------------------------
	// Stimulus
	// ------------------------------------------------------------
	initial begin
		nrst = 1'b0;
		ce = 1'b1;
		{uv_lock, bs, bst, sdh, sdl, phe, phi, ovr, und} = '0;
		idle(5);
		foreach (ROWS[i]) begin
			{uv_lock, bs, bst, sdh, sdl} = ROWS[i][6:2];
			nrst = 1'b0;
			idle(2);
			nrst = 1'b1;
			idle(15);
			chk({osc_enable, micropower}, ROWS[i][1:0]);
		end
		gates(3 * HC);
		ovr = 1'b1;
		und = 1'b1;
		idle(3 * HC);
		chk({preheat_release, fault_latched}, 2'h0);
		ovr = 1'b0;
		phe = 1'b1;
		wait_for(1, 1'b1, 10);
		chk({run_select, fault_latched}, 2'h0);
		und = 1'b0;
		phi = 1'b1;
		wait_for(2, 1'b1, 10);
		bs = 1'b0;
		idle(20);
		chk({osc_enable, run_select}, 2'h3);
		{bst, phe, phi} = 3'h0;
		wait_for(0, 1'b0, 6);
		off_chk(1'b0);
		{bs, bst} = 2'h3;
		wait_for(0, 1'b1, 10);
		chk({preheat_release, run_select}, 2'h0);
		phe = 1'b1;
		wait_for(1, 1'b1, 10);
		{sdh, sdl} = 2'h3;
		wait_for(0, 1'b0, 6);
		off_chk(1'b1);
		sdh = 1'b0;
		idle(20);
		off_chk(1'b1);
		sdl = 1'b0;
		wait_for(0, 1'b1, 10);
		chk({micropower, preheat_release}, 2'h0);
		wait_for(1, 1'b1, 10);
		ovr = 1'b1;
		wait_for(3, 1'b1, 2 * HC + 5);
		off_chk(1'b1);
		ovr = 1'b0;
		idle(2 * HC);
		chk({osc_enable, fault_latched}, 2'h1);
		{sdh, sdl} = 2'h3;
		wait_for(3, 1'b0, 8);
		off_chk(1'b1);
		{sdh, sdl} = 2'h0;
		wait_for(0, 1'b1, 10);
		phi = 1'b1;
		wait_for(2, 1'b1, 12);
		und = 1'b1;
		wait_for(3, 1'b1, 3 * HC);
		off_chk(1'b1);
		und = 1'b0;
		uv_lock = 1'b1;
		wait_for(3, 1'b0, 8);
		uv_lock = 1'b0;
		wait_for(0, 1'b1, 12);
		nrst = 1'b0;
		idle(1);
		off_chk(1'b0);
		chk({run_select, fault_latched}, 2'h0);
		nrst = 1'b1;
		wait_for(0, 1'b1, 15);
		test_done();
	end
endmodule : bfp_top_tb_top

// ==== rtl/bfp_pkg.sv ====
// Shared constants and types for the ballast fault protection and restart block
package bfp_pkg;

	// ------------------------------------------------------------
	// Synchronised comparator input positions
	// ------------------------------------------------------------
	localparam int SYNC_W = 8;
	localparam int IDX_UV_LOCK = 0;
	localparam int IDX_BUS_START = 1;
	localparam int IDX_BUS_STOP = 2;
	localparam int IDX_LAMP_OFF_HI = 3;
	localparam int IDX_LAMP_OFF_LOW = 4;
	localparam int IDX_CS_OVER = 5;
	localparam int IDX_PH_END = 6;
	localparam int IDX_IGN_END = 7;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 5000;
	localparam int OSC_HALF_PERIOD_NS = 10000;
	localparam int DEAD_TIME_NS = 1000;
	localparam int OSC_HALF_CYC = (OSC_HALF_PERIOD_NS * 1000) / CLK_PERIOD_PS;
	localparam int DEAD_CYC = (DEAD_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CNT_W = 12;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [SYNC_W-1:0] SYNC_RST = 8'h00;
	localparam logic [CNT_W-1:0] CNT_RST = 12'h000;

	// ------------------------------------------------------------
	// Control sequence states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_OFF,
		ST_PREHEAT,
		ST_IGNITE,
		ST_RUN
	} bfp_state_t;

endpackage : bfp_pkg

// ==== rtl/bfp_sync.sv ====
// Two-flop synchroniser for a vector of comparator flags
`timescale 1ns/1ps
module bfp_sync
	import bfp_pkg::*;
#(
	parameter int W = SYNC_W
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ce,
	// Flags
	bfp_sync_if.dst sif
);
	logic [W-1:0] s1_q, s1_d;
	logic [W-1:0] s2_q, s2_d;

	// ------------------------------------------------------------
	// Two stages
	// ------------------------------------------------------------
	always_comb begin
		s1_d = ce ? sif.raw : s1_q;
		s2_d = ce ? s1_q : s2_q;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= W'(SYNC_RST);
			s2_q <= W'(SYNC_RST);
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
		end
	end

	assign sif.sync = s2_q;
endmodule : bfp_sync

// ==== rtl/bfp_sync_if.sv ====
// Interface carrying comparator flags into and out of the synchroniser
`timescale 1ns/1ps
interface bfp_sync_if #(parameter int W = 8);
	logic [W-1:0] raw;
	logic [W-1:0] sync;
	modport src (output raw, input sync);
	modport dst (input raw, output sync);
endinterface : bfp_sync_if

// ==== rtl/bfp_top.sv ====
// Protection and restart supervisor of the ballast controller
// ------------------------------------------------------------
// How it works
// - Start needs supply, bus and shutdown ok
// - Low bus during operation stops oscillator
// - Bus comparator hysteresis between start, stop
// - Bus recovery restarts from preheat
// - Shutdown high: oscillator off, gates low, micropower
// - Shutdown low again restarts sequence
// - Current fault latches, stops, enters micropower
// - Current faults checked every switching cycle
// - Over-current threshold active after preheat only
// - Under-current threshold active in run only
// - Under-current sampled at low-gate falling edge
// - Shutdown high clears fault, stays off
// - Shutdown low after fault restarts startup
// - Undervoltage lock clears fault latch
// - Preheat node low threshold starts ignition
// - Preheat node high threshold enters run
// ------------------------------------------------------------
`timescale 1ns/1ps
module bfp_top
	import bfp_pkg::*;
#(
	parameter int HALF_CYC = OSC_HALF_CYC,
	parameter int DEAD = DEAD_CYC
) (
	// Clock, reset, enable
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic ce,
	// Comparator flags
	input wire logic supply_undervoltage_lock,
	input wire logic bus_above_start,
	input wire logic bus_above_stop,
	input wire logic shutdown_above_high,
	input wire logic shutdown_above_low,
	input wire logic cs_above_over,
	input wire logic cs_below_under,
	input wire logic preheat_node_above_end,
	input wire logic preheat_node_above_ignite,
	// Drive outputs
	output logic osc_enable,
	output logic high_side_gate_out,
	output logic low_side_gate_out,
	output logic preheat_release,
	output logic run_select,
	// Status
	output logic micropower,
	output logic fault_latched
);
	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic rst1_q, rst_n;
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rst1_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst1_q <= 1'b1;
			rst_n <= rst1_q;
		end
	end

	// ------------------------------------------------------------
	// Input synchronisation
	// ------------------------------------------------------------
	bfp_sync_if #(.W(SYNC_W)) sif ();
	assign sif.raw[IDX_UV_LOCK] = supply_undervoltage_lock;
	assign sif.raw[IDX_BUS_START] = bus_above_start;
	assign sif.raw[IDX_BUS_STOP] = bus_above_stop;
	assign sif.raw[IDX_LAMP_OFF_HI] = shutdown_above_high;
	assign sif.raw[IDX_LAMP_OFF_LOW] = shutdown_above_low;
	assign sif.raw[IDX_CS_OVER] = cs_above_over;
	assign sif.raw[IDX_PH_END] = preheat_node_above_end;
	assign sif.raw[IDX_IGN_END] = preheat_node_above_ignite;

	bfp_sync #(.W(SYNC_W)) u_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.ce(ce),
		.sif(sif)
	);

	logic uv_lock_s, bus_start_s, bus_stop_s, lamp_off_hi_s, lamp_off_low_s, cs_over_s, ph_s, ign_s;
	assign uv_lock_s = sif.sync[IDX_UV_LOCK];
	assign bus_start_s = sif.sync[IDX_BUS_START];
	assign bus_stop_s = sif.sync[IDX_BUS_STOP];
	assign lamp_off_hi_s = sif.sync[IDX_LAMP_OFF_HI];
	assign lamp_off_low_s = sif.sync[IDX_LAMP_OFF_LOW];
	assign cs_over_s = sif.sync[IDX_CS_OVER];
	assign ph_s = sif.sync[IDX_PH_END];
	assign ign_s = sif.sync[IDX_IGN_END];

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	bfp_state_t st_q, st_d;
	logic bus_ok_q, bus_ok_d;
	logic lamp_off_q, lamp_off_d;
	logic fault_q, fault_d;
	logic uc_q, uc_d;
	logic phase_q, phase_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic hs_q, hs_d;
	logic ls_q, ls_d;
	logic running_q, running_d;
	logic start_ok, keep_ok, oc_hit, fault_set, fault_clr, low_gate_fall, run_d;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		// Bus hysteresis: set above start level, cleared only below stop level
		bus_ok_d = bus_start_s ? 1'b1 : (!bus_stop_s ? 1'b0 : bus_ok_q);
		lamp_off_d = lamp_off_hi_s ? 1'b1 : (!lamp_off_low_s ? 1'b0 : lamp_off_q);
		start_ok = !uv_lock_s && bus_ok_q && !lamp_off_q && !fault_q;
		keep_ok = start_ok;
		// Over-current seen in any single low-side conduction interval in ignite or run
		oc_hit = (st_q == ST_IGNITE || st_q == ST_RUN) && ls_q && cs_over_s;
		fault_set = oc_hit || uc_q;
		fault_clr = lamp_off_q || uv_lock_s;
		fault_d = fault_set ? 1'b1 : (fault_clr ? 1'b0 : fault_q);
		st_d = st_q;
		case (st_q)
			ST_OFF: begin
				// Every start goes through preheat
				// A fault caught while stopping must not slip into a start
				if (start_ok && !fault_set) begin
					st_d = ST_PREHEAT;
				end
			end
			ST_PREHEAT: begin
				if (ph_s) begin
					st_d = ST_IGNITE;
				end
			end
			ST_IGNITE: begin
				if (ign_s) begin
					st_d = ST_RUN;
				end
			end
			ST_RUN: begin
				st_d = ST_RUN;
			end
			default: begin
				st_d = ST_OFF;
			end
		endcase
		if (st_q != ST_OFF && (!keep_ok || fault_set)) begin
			st_d = ST_OFF;
		end
		run_d = (st_d != ST_OFF);
		running_d = run_d;
		// Oscillator with alternating halves and dead time
		if (!run_d) begin
			cnt_d = CNT_RST;
			phase_d = 1'b0;
		end else if (cnt_q >= CNT_W'(HALF_CYC - 1)) begin
			cnt_d = CNT_RST;
			phase_d = !phase_q;
		end else begin
			cnt_d = cnt_q + 12'h001;
			phase_d = phase_q;
		end
		hs_d = run_d && phase_d && (cnt_d >= CNT_W'(DEAD));
		ls_d = run_d && !phase_d && (cnt_d >= CNT_W'(DEAD));
		low_gate_fall = ls_q && !ls_d;
		// Under-current sampled once per cycle at the low-gate fall
		uc_d = low_gate_fall && (st_q == ST_RUN) && cs_below_under;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= ST_OFF;
			bus_ok_q <= 1'b0;
			lamp_off_q <= 1'b0;
			fault_q <= 1'b0;
			uc_q <= 1'b0;
			phase_q <= 1'b0;
			cnt_q <= CNT_RST;
			hs_q <= 1'b0;
			ls_q <= 1'b0;
			running_q <= 1'b0;
		end else if (ce) begin
			st_q <= st_d;
			bus_ok_q <= bus_ok_d;
			lamp_off_q <= lamp_off_d;
			fault_q <= fault_d;
			uc_q <= uc_d;
			phase_q <= phase_d;
			cnt_q <= cnt_d;
			hs_q <= hs_d;
			ls_q <= ls_d;
			running_q <= running_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign osc_enable = running_q;
	assign high_side_gate_out = hs_q;
	assign low_side_gate_out = ls_q;
	assign preheat_release = (st_q == ST_IGNITE) || (st_q == ST_RUN);
	assign run_select = (st_q == ST_RUN);
	assign micropower = lamp_off_q || fault_q;
	assign fault_latched = fault_q;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_start_hold;
		@(posedge clk_sys) disable iff (!rst_n)
		(ce && st_q == ST_OFF && !start_ok) |=> (st_q == ST_OFF && !osc_enable);
	endproperty
	a_start_hold: assert property (p_start_hold) else $error("start without conditions");

	property p_bus_stop;
		@(posedge clk_sys) disable iff (!rst_n)
		(ce && st_q != ST_OFF && !bus_ok_q) |=> (st_q == ST_OFF && !hs_q && !ls_q);
	endproperty
	a_bus_stop: assert property (p_bus_stop) else $error("low bus did not stop");

	property p_bus_hyst;
		@(posedge clk_sys) disable iff (!rst_n)
		(ce && bus_ok_q && bus_stop_s) |=> bus_ok_q;
	endproperty
	a_bus_hyst: assert property (p_bus_hyst) else $error("bus ok dropped above stop");

	property p_restart;
		@(posedge clk_sys) disable iff (!rst_n)
		(ce && st_q == ST_OFF && start_ok && !fault_set) |=> (st_q == ST_PREHEAT && !preheat_release);
	endproperty
	a_restart: assert property (p_restart) else $error("restart not at preheat");

	property p_sd_off;
		@(posedge clk_sys) disable iff (!rst_n)
		(ce && lamp_off_q) |-> (micropower ##1 (!hs_q && !ls_q && !osc_enable));
	endproperty
	a_sd_off: assert property (p_sd_off) else $error("shutdown did not stop");

	property p_fault;
		@(posedge clk_sys) disable iff (!rst_n)
		(ce && fault_set) |=> (fault_latched && micropower && !hs_q && !ls_q);
	endproperty
	a_fault: assert property (p_fault) else $error("fault not latched");

	property p_oc_window;
		@(posedge clk_sys) disable iff (!rst_n)
		(ce && st_q == ST_PREHEAT && !fault_latched) |=> !fault_latched;
	endproperty
	a_oc_window: assert property (p_oc_window) else $error("over-current before ignition");

	property p_uc_window;
		@(posedge clk_sys) disable iff (!rst_n)
		(ce && uc_d) |-> ($fell(ls_d) && st_q == ST_RUN);
	endproperty
	a_uc_window: assert property (p_uc_window) else $error("under-current check misplaced");

	property p_sd_clear;
		@(posedge clk_sys) disable iff (!rst_n)
		(ce && (lamp_off_q || uv_lock_s) && !fault_set) |=> !fault_latched;
	endproperty
	a_sd_clear: assert property (p_sd_clear) else $error("fault not cleared");

	property p_ignite;
		@(posedge clk_sys) disable iff (!rst_n)
		(ce && st_q == ST_PREHEAT && ph_s && keep_ok) |=> (st_q == ST_IGNITE && preheat_release);
	endproperty
	a_ignite: assert property (p_ignite) else $error("preheat end missed");

	property p_run;
		@(posedge clk_sys) disable iff (!rst_n)
		(ce && st_q == ST_IGNITE && ign_s && keep_ok && !fault_set) |=> run_select;
	endproperty
	a_run: assert property (p_run) else $error("run mode not entered");

	c_run: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(run_select));
	c_fault: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(fault_latched));
	c_uc: cover property (@(posedge clk_sys) disable iff (!rst_n) uc_q);
	c_restart: cover property (@(posedge clk_sys) disable iff (!rst_n)
		$fell(lamp_off_q) ##[1:20] osc_enable);
endmodule : bfp_top
